// [design/dmwd_irq.sv]
`timescale 1ns/1ns
module dmwd_irq #(
  parameter int N = dmwd_pkg::EVT_N
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  input wire logic mask_wr,
  input wire logic [N-1:0] mask_wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);
  import dmwd_pkg::*;

  logic [N-1:0] sts_q;
  logic [N-1:0] mask_q;

  // ---------------------------------------------------------------
  // Sticky bits, set wins over write-one-to-clear
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          sts_q[i] <= 1'b0;
        end else begin
          sts_q[i] <= set[i] | (sts_q[i] & ~clr[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mask_q <= N'(MASK_RST);
    end else if (mask_wr) begin
      mask_q <= mask_wdata;
    end
  end

  assign status = sts_q;
  assign mask = mask_q;
  assign irq = |(sts_q & mask_q);

endmodule

// [design/dmwd_tick.sv]
`timescale 1ns/1ns
module dmwd_tick #(
  parameter int DIV = dmwd_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);
  import dmwd_pkg::*;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;

  initial begin
    if (DIV < 1) begin
      $error("DIV must be at least 1");
    end
  end

  // ---------------------------------------------------------------
  // Divider: one-cycle enable every DIV clocks
  // ---------------------------------------------------------------
  assign tick = (div_q == LAST);
  assign div_d = tick ? '0 : div_q + CW'(1);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

endmodule

// [design/dmwd_top.sv]
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module dmwd_top #(
  parameter int CNT_W = dmwd_pkg::CNT_W_DEF,
  parameter int TICK_DIV = dmwd_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire dmwd_pkg::dmwd_av_req_t av_req,
  output logic av_waitrequest,
  output logic [31:0] av_readdata,
  output logic warm_reset_o,
  output logic irq_o
);
  import dmwd_pkg::*;

  initial begin
    if (CNT_W < 2 || CNT_W > 16) begin
      $error("CNT_W must lie in 2..16");
    end
  end

  // ---------------------------------------------------------------
  // Bus slave: one wait cycle per access
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_go;
  logic hit_ctrl;
  logic hit_timeout;
  logic hit_lower;
  logic hit_key;
  logic hit_count;
  logic hit_status;
  logic hit_mask;
  logic [31:0] rmux;

  assign req = av_req.read | av_req.write;
  assign av_waitrequest = req & ~ack_q;
  assign wr_go = av_req.write & ack_q;
  assign hit_ctrl = (av_req.address == OFS_CTRL);
  assign hit_timeout = (av_req.address == OFS_TIMEOUT);
  assign hit_lower = (av_req.address == OFS_LOWER);
  assign hit_key = (av_req.address == OFS_KEY);
  assign hit_count = (av_req.address == OFS_COUNT);
  assign hit_status = (av_req.address == OFS_STATUS);
  assign hit_mask = (av_req.address == OFS_MASK);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (av_req.read & ~ack_q) begin
        rdata_q <= rmux;
      end
    end
  end

  assign av_readdata = rdata_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  dmwd_mode_t mode_q;
  dmwd_resp_t resp_q;
  logic [CNT_W-1:0] timeout_q;
  logic [CNT_W-1:0] lower_q;
  logic ctrl_wr;

  assign ctrl_wr = wr_go & hit_ctrl;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_q <= MODE_SINGLE;
      resp_q <= RESP_IRQ;
    end else if (ctrl_wr) begin
      mode_q <= dmwd_mode_t'(av_req.writedata[CTRL_MODE_BIT]);
      resp_q <= dmwd_resp_t'(av_req.writedata[CTRL_RESP_BIT]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timeout_q <= TIMEOUT_RST[CNT_W-1:0];
      lower_q <= LOWER_RST[CNT_W-1:0];
    end else begin
      if (wr_go & hit_timeout) begin
        timeout_q <= av_req.writedata[CNT_W-1:0];
      end
      if (wr_go & hit_lower) begin
        lower_q <= av_req.writedata[CNT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Counter and key check
  // ---------------------------------------------------------------
  logic tick;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic key_wr;
  logic key_match;
  logic key_good;
  logic in_window;
  logic expire;
  logic restart;
  logic err_any;
  dmwd_evt_t evt;

  dmwd_tick #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  assign key_wr = wr_go & hit_key;
  assign key_match = (av_req.writedata == SERVICE_KEY);
  assign in_window = (mode_q == MODE_SINGLE) || (cnt_q >= lower_q);
  assign key_good = key_wr & key_match & in_window;
  assign expire = tick & (cnt_q >= timeout_q) & ~key_wr;

  // wrong key, early key or counter expiry
  assign evt.expired = expire;
  assign evt.bad_key = key_wr & ~key_match;
  // early key exists only in windowed mode
  assign evt.early = key_wr & key_match & ~in_window;
  assign err_any = |evt;
  assign restart = key_wr | expire;

  assign cnt_d = restart ? '0 : (tick ? cnt_q + CNT_W'(1) : cnt_q);

  // counts from reset with no setup
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Error response
  // ---------------------------------------------------------------
  logic [EVT_N-1:0] sts;
  logic [EVT_N-1:0] msk;
  logic [EVT_N-1:0] sts_set;
  logic [EVT_N-1:0] sts_clr;
  logic irq_raw;

  assign sts_set = (resp_q == RESP_IRQ) ? evt : '0;
  assign sts_clr = (wr_go & hit_status) ? av_req.writedata[EVT_N-1:0] : '0;

  dmwd_irq #(
    .N(EVT_N)
  ) u_irq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set(sts_set),
    .clr(sts_clr),
    .mask_wr(wr_go & hit_mask),
    .mask_wdata(av_req.writedata[EVT_N-1:0]),
    .status(sts),
    .mask(msk),
    .irq(irq_raw)
  );

  assign irq_o = irq_raw;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      warm_reset_o <= 1'b0;
    end else begin
      warm_reset_o <= err_any & (resp_q == RESP_RESET);
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  assign rmux = hit_ctrl ? {30'h0, resp_q, mode_q} :
                hit_timeout ? 32'(timeout_q) :
                hit_lower ? 32'(lower_q) :
                hit_count ? 32'(cnt_q) :
                hit_status ? 32'(sts) :
                hit_mask ? 32'(msk) : 32'h0;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic rst_seen_q;

  always_ff @(posedge clk_sys) begin
    rst_seen_q <= ~rst_n;
  end

  property p_mode_excl;
    @(posedge clk_sys) disable iff (!rst_n)
      evt.early |-> mode_q == MODE_WINDOW && cnt_q < lower_q;
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("early key flagged outside windowed mode");

  property p_expire;
    @(posedge clk_sys) disable iff (!rst_n)
      tick && cnt_q >= timeout_q && !key_wr && resp_q == RESP_IRQ
      |=> sts[EVT_EXPIRED] && cnt_q == '0;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not flag and restart");

  property p_resp;
    @(posedge clk_sys) disable iff (!rst_n)
      err_any && !ctrl_wr |=> (warm_reset_o == (resp_q == RESP_RESET))
      && (resp_q == RESP_RESET || (sts & $past(evt)) == $past(evt))
      && (resp_q == RESP_IRQ || (sts & ~$past(sts)) == '0);
  endproperty
  a_resp: assert property (p_resp)
    else $error("error response does not match configuration");

  property p_starts;
    @(posedge clk_sys)
      rst_seen_q && rst_n |-> ##[1:300] cnt_q != '0 || key_wr;
  endproperty
  a_starts: assert property (p_starts)
    else $error("counter did not start after reset");

  property p_window_ok;
    @(posedge clk_sys) disable iff (!rst_n)
      key_wr && key_match && mode_q == MODE_WINDOW && cnt_q >= lower_q
      |=> !warm_reset_o && cnt_q == '0;
  endproperty
  a_window_ok: assert property (p_window_ok)
    else $error("in-window key was not accepted");

  property p_bad_key;
    @(posedge clk_sys) disable iff (!rst_n)
      key_wr && !key_match && resp_q == RESP_RESET |=> warm_reset_o ##1
      !warm_reset_o || $past(err_any);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("wrong key gave no single reset pulse");

  property p_default_mode;
    @(posedge clk_sys) disable iff (!rst_n)
      rst_seen_q || $changed(mode_q) |-> rst_seen_q ?
      mode_q == MODE_SINGLE : $past(ctrl_wr);
  endproperty
  a_default_mode: assert property (p_default_mode)
    else $error("mode not single after reset or changed without write");

  property p_good_key;
    @(posedge clk_sys) disable iff (!rst_n)
      key_good |=> cnt_q == '0 && !warm_reset_o;
  endproperty
  a_good_key: assert property (p_good_key)
    else $error("good key did not restart cleanly");

  property p_one_wait;
    @(posedge clk_sys) disable iff (!rst_n)
      av_waitrequest |=> !req || !av_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus access waited more than one cycle");

  property p_window_miss;
    @(posedge clk_sys) disable iff (!rst_n)
      mode_q == MODE_WINDOW && expire && resp_q == RESP_IRQ
      |=> sts[EVT_EXPIRED] && cnt_q == '0;
  endproperty
  a_window_miss: assert property (p_window_miss)
    else $error("missed window was not flagged");

  c_good_key: cover property (@(posedge clk_sys) disable iff (!rst_n)
    key_good ##1 tick);
  c_window_early: cover property (@(posedge clk_sys) disable iff (!rst_n)
    evt.early);
  c_expire_irq: cover property (@(posedge clk_sys) disable iff (!rst_n)
    expire ##1 irq_o);
  c_reset_out: cover property (@(posedge clk_sys) disable iff (!rst_n)
    warm_reset_o);
  c_window_miss: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mode_q == MODE_WINDOW && expire);

endmodule

// [include/dmwd_pkg.sv]
package dmwd_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMEOUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_KEY = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h18;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_RESP_BIT = 1;
  localparam int CNT_W_DEF = 16;
  localparam logic [15:0] TIMEOUT_RST = 16'hffff;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [31:0] SERVICE_KEY = 32'h0000_5a3c;
  localparam int EVT_N = 3;
  localparam int EVT_EXPIRED = 0;
  localparam int EVT_BAD_KEY = 1;
  localparam int EVT_EARLY = 2;
  localparam logic [EVT_N-1:0] MASK_RST = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    MODE_SINGLE = 1'b0,
    MODE_WINDOW = 1'b1
  } dmwd_mode_t;

  typedef enum logic {
    RESP_IRQ = 1'b0,
    RESP_RESET = 1'b1
  } dmwd_resp_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } dmwd_av_req_t;

  typedef struct packed {
    logic early;
    logic bad_key;
    logic expired;
  } dmwd_evt_t;

endpackage

// [test/tb.sv]
`timescale 1ns/1ns
module tb;
  import dmwd_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk_sys;
  logic rst_n;
  dmwd_av_req_t av_req;
  logic av_waitrequest;
  logic [31:0] av_readdata;
  logic warm_reset_o;
  logic irq_o;
  int error_cnt;
  int comparisons;
  int pulses;
  int p0;
  logic [31:0] rd;
  logic [31:0] lfsr_q;
  logic [31:0] keys [8];

  dmwd_top #(.CNT_W(16), .TICK_DIV(2)) dmwd_top_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .av_req(av_req),
    .av_waitrequest(av_waitrequest),
    .av_readdata(av_readdata),
    .warm_reset_o(warm_reset_o),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------
  // Clock, pulse monitor, helpers
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (warm_reset_o === 1'b1) begin
      pulses++;
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] key_status(input logic [31:0] k);
    return (k == SERVICE_KEY) ? 32'h0 : 32'h2;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int waits;
    waits = 0;
    @(posedge clk_sys);
    av_req <= '{read: ~w, write: w, address: a, writedata: d};
    do begin
      @(posedge clk_sys);
      waits++;
    end while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_req <= '0;
    chk("waitrequest", 32'(waits), 32'h2);
  endtask

  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    av_req = '0;
    rst_n = 1'b0;
    lfsr_q = 32'h6822caeb;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("ctrl_rst", OFS_CTRL, 32'h0);
    rchk("timeout_rst", OFS_TIMEOUT, {16'h0, TIMEOUT_RST});
    rchk("lower_rst", OFS_LOWER, {16'h0, LOWER_RST});
    rchk("mask_rst", OFS_MASK, 32'h0);
    rchk("status_rst", OFS_STATUS, 32'h0);
    bus(1'b1, 8'h1c, 32'hffff_ffff);
    rchk("unmapped", 8'h1c, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    p0 = int'(rd);
    repeat (20) @(posedge clk_sys);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("counting", 32'(int'(rd) > p0), 32'h1);
    // Back-to-back good keys are fine outside windowed mode
    // key before expiry
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count_restart", 32'(rd < 3), 32'h1);
    rchk("status_good", OFS_STATUS, 32'h0);
    // Random and corner keys in single-threshold mode
    keys[0] = SERVICE_KEY ^ 32'h1;
    keys[1] = SERVICE_KEY | 32'h8000_0000;
    keys[2] = 32'h0;
    for (int i = 3; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      keys[i] = lfsr_q;
    end
    foreach (keys[i]) begin
      bus(1'b1, OFS_KEY, keys[i]);
      settle();
      rchk("key_judge", OFS_STATUS, key_status(keys[i]));
      bus(1'b1, OFS_STATUS, 32'h7);
    end
    // Interrupt: raise, mask, clear
    bus(1'b1, OFS_KEY, SERVICE_KEY ^ 32'h10);
    settle();
    chk("irq_masked", {31'h0, irq_o}, 32'h0);
    bus(1'b1, OFS_MASK, 32'h2);
    rchk("mask_rb", OFS_MASK, 32'h2);
    settle();
    chk("irq_on", {31'h0, irq_o}, 32'h1);
    bus(1'b1, OFS_STATUS, 32'h2);
    settle();
    chk("irq_clr", {31'h0, irq_o}, 32'h0);
    // Expiry in single-threshold mode
    bus(1'b1, OFS_MASK, 32'h1);
    bus(1'b1, OFS_TIMEOUT, 32'h4);
    repeat (40) @(posedge clk_sys);
    #1;
    chk("irq_expiry", {31'h0, irq_o}, 32'h1);
    rchk("status_exp", OFS_STATUS, 32'h1);
    bus(1'b1, OFS_TIMEOUT, 32'hffff);
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    bus(1'b1, OFS_STATUS, 32'h7);
    // Warm reset response
    bus(1'b1, OFS_CTRL, 32'h2);
    p0 = pulses;
    bus(1'b1, OFS_KEY, SERVICE_KEY ^ 32'h100);
    settle();
    chk("warm_pulse", 32'(pulses - p0), 32'h1);
    rchk("status_wrm", OFS_STATUS, 32'h0);
    p0 = pulses;
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    settle();
    chk("warm_none", 32'(pulses - p0), 32'h0);
    // Windowed mode
    bus(1'b1, OFS_CTRL, 32'h1);
    rchk("ctrl_win", OFS_CTRL, 32'h1);
    bus(1'b1, OFS_LOWER, 32'd20);
    bus(1'b1, OFS_TIMEOUT, 32'd200);
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    bus(1'b1, OFS_STATUS, 32'h7);
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    settle();
    rchk("early_key", OFS_STATUS, 32'h4);
    bus(1'b1, OFS_STATUS, 32'h7);
    repeat (60) @(posedge clk_sys);
    bus(1'b1, OFS_KEY, SERVICE_KEY);
    settle();
    rchk("window_ok", OFS_STATUS, 32'h0);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("win_restart", 32'(rd < 5), 32'h1);
    repeat (60) @(posedge clk_sys);
    lfsr_q = lfsr_next(lfsr_q);
    bus(1'b1, OFS_KEY, lfsr_q);
    settle();
    rchk("win_badkey", OFS_STATUS, key_status(lfsr_q));
    bus(1'b1, OFS_STATUS, 32'h7);
    bus(1'b1, OFS_TIMEOUT, 32'd30);
    repeat (120) @(posedge clk_sys);
    rchk("win_expiry", OFS_STATUS, 32'h1);
    final_report();
  end
endmodule
